/* rtl/psr_regs.svh */
/*
 Register offsets, field positions and reset values of the protection
 signal routing matrix. Assumes byte addresses on an 8-bit address port.
*/
`ifndef PSR_REGS_SVH
`define PSR_REGS_SVH

// ==========================================================
// Offsets
`define PSR_OFF_INPUT_CTRL   8'h00
`define PSR_OFF_ROUTE_OPEN1  8'h04
`define PSR_OFF_ROUTE_SIG34  8'h08
`define PSR_OFF_ROUTE_SIG2   8'h0c
`define PSR_OFF_FUNC_SEL     8'h10
`define PSR_OFF_IRQ_STATUS   8'h14
`define PSR_OFF_IRQ_MASK     8'h18
`define PSR_OFF_LIVE_STATE   8'h1c
`define PSR_OFF_COMMAND      8'h20

// ==========================================================
// Reset values
`define PSR_RST_INPUT_CTRL   8'h00
`define PSR_RST_ROUTE_OPEN1  8'hab
`define PSR_RST_ROUTE_SIG34  8'ha5
`define PSR_RST_ROUTE_SIG2   8'h00
`define PSR_RST_FUNC_SEL     8'h00
`define PSR_RST_IRQ_MASK     4'h0

// ==========================================================
// Input control fields
`define PSR_IC_BANK2         4
`define PSR_IC_LATCH_OC      5
`define PSR_IC_LATCH_EF      6
`define PSR_IC_REMOTE_RST    7

// ==========================================================
// Function select fields
`define PSR_FS_CBFP          3
`define PSR_FS_HS_DOUBLE     4

// ==========================================================
// Interrupt status bits
`define PSR_EV_OPEN          0
`define PSR_EV_BLOCK         1
`define PSR_EV_LATCH         2
`define PSR_EV_REMOTE_RST    3

// ==========================================================
// Command fields
`define PSR_CMD_LATCH_RST    0

`endif

/* rtl/psr_pkg.sv */
/*
 Types of the protection signal routing matrix.
 Assumes nothing of its surroundings.
*/
package psr_pkg;
   typedef logic [7:0] psr_sw_t;
   typedef logic [3:0] psr_ev_t;
   // Stage order on the stage vectors
   typedef enum logic [1:0] {
      PSR_PH_LOW  = 2'h0,
      PSR_PH_HIGH = 2'h1,
      PSR_EF_LOW  = 2'h2,
      PSR_EF_HIGH = 2'h3
   } psr_stage_t;
endpackage : psr_pkg

/* rtl/psr_matrix.sv */
/*
 Protection signal routing matrix: switch registers that route stage start
 and trip signals to the breaker open and four signal outputs, handle the
 binary control input, latch trip signal two and select characteristics.
 Assumes stage signals and the control input are synchronous to sys_clk and
 that a register master drives one-cycle strobes.
*/
`timescale 1ns/1ps
`include "psr_regs.svh"

module psr_matrix #(
   parameter int NUM_STAGES = 4,
   parameter int SW_W       = 8
) (
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst,
   // Register port
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wr_data,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rd_data,
   // Protection stages
   input  wire logic [3:0] stage_start,
   input  wire logic [3:0] stage_trip,
   input  wire logic       ctrl_in,
   input  wire logic       energizing,
   // Relay outputs
   output logic            trip_open,
   output logic            signal1,
   output logic            signal2,
   output logic            signal3,
   output logic            signal4,
   // Stage control
   output logic            bank2_sel,
   output logic [2:0]      ph_low_char,
   output logic [2:0]      ef_low_char,
   output logic            cbfp_en,
   output logic            hs_double,
   output logic            rec_clear,
   // Interrupt
   output logic            irq
);

   // ==========================================================
   // Parameter check
   if (NUM_STAGES != 4 || SW_W != 8) begin : g_chk
      $error("psr_matrix serves four stages with eight-bit switch groups");
   end

   // ==========================================================
   // Switch registers
   psr_pkg::psr_sw_t input_control_switches;
   psr_pkg::psr_sw_t routing_group_open_signal1;
   psr_pkg::psr_sw_t routing_group_signal3_signal4;
   psr_pkg::psr_sw_t routing_group_signal2;
   psr_pkg::psr_sw_t function_select_switches;
   psr_pkg::psr_ev_t irq_status_reg;
   psr_pkg::psr_ev_t irq_mask_reg;
   psr_pkg::psr_ev_t irq_status_next;
   psr_pkg::psr_ev_t irq_mask_next;
   psr_pkg::psr_ev_t ev_set;

   logic wr_ic;
   logic wr_r1;
   logic wr_r2;
   logic wr_r3;
   logic wr_fs;
   logic wr_st;
   logic wr_mk;
   logic wr_cmd;

   assign wr_ic  = reg_wr && reg_addr == `PSR_OFF_INPUT_CTRL;
   assign wr_r1  = reg_wr && reg_addr == `PSR_OFF_ROUTE_OPEN1;
   assign wr_r2  = reg_wr && reg_addr == `PSR_OFF_ROUTE_SIG34;
   assign wr_r3  = reg_wr && reg_addr == `PSR_OFF_ROUTE_SIG2;
   assign wr_fs  = reg_wr && reg_addr == `PSR_OFF_FUNC_SEL;
   assign wr_st  = reg_wr && reg_addr == `PSR_OFF_IRQ_STATUS;
   assign wr_mk  = reg_wr && reg_addr == `PSR_OFF_IRQ_MASK;
   assign wr_cmd = reg_wr && reg_addr == `PSR_OFF_COMMAND;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         input_control_switches        <= `PSR_RST_INPUT_CTRL;
         routing_group_open_signal1    <= `PSR_RST_ROUTE_OPEN1;
         routing_group_signal3_signal4 <= `PSR_RST_ROUTE_SIG34;
         routing_group_signal2         <= `PSR_RST_ROUTE_SIG2;
         function_select_switches      <= `PSR_RST_FUNC_SEL;
      end else begin
         if (wr_ic) begin
            input_control_switches <= reg_wr_data;
         end
         if (wr_r1) begin
            routing_group_open_signal1 <= reg_wr_data;
         end
         if (wr_r2) begin
            routing_group_signal3_signal4 <= reg_wr_data;
         end
         if (wr_r3) begin
            routing_group_signal2 <= reg_wr_data;
         end
         if (wr_fs) begin
            function_select_switches <= reg_wr_data;
         end
      end
   end

   // ==========================================================
   // Per-stage routing masks
   logic [3:0] blk_mask;
   logic [3:0] s1_start_mask;
   logic [3:0] open_trip_mask;
   logic [3:0] s3_trip_mask;
   logic [3:0] s4_trip_mask;
   logic [3:0] s2_start_mask;
   logic [3:0] s2_trip_mask;
   logic [3:0] trip_eff;

   for (genvar i = 0; i < 4; i++) begin : g_stage
      // Bit one of a group is bit 0; pairs of bits per stage
      assign blk_mask[i]       = input_control_switches[i];
      assign s1_start_mask[i]  = routing_group_open_signal1[2*i];
      assign open_trip_mask[i] = routing_group_open_signal1[2*i+1];
      assign s3_trip_mask[i]   = routing_group_signal3_signal4[2*i];
      assign s4_trip_mask[i]   = routing_group_signal3_signal4[2*i+1];
      assign s2_start_mask[i]  = routing_group_signal2[2*i];
      assign s2_trip_mask[i]   = routing_group_signal2[2*i+1];
      // Blocked stages lose their trip only
      assign trip_eff[i] = stage_trip[i] && !(ctrl_in && blk_mask[i]);
   end

   // ==========================================================
   // Control input functions
   logic remote_rst;
   logic remote_rst_d_reg;
   logic latch_clr;
   logic oc_fault;
   logic ef_fault;
   logic lat_oc_reg;
   logic lat_ef_reg;

   assign remote_rst = ctrl_in && input_control_switches[`PSR_IC_REMOTE_RST];
   assign latch_clr  = remote_rst || (wr_cmd && reg_wr_data[`PSR_CMD_LATCH_RST]);
   assign oc_fault   = |(trip_eff[1:0] & open_trip_mask[1:0]);
   assign ef_fault   = |(trip_eff[3:2] & open_trip_mask[3:2]);

   // Latches of trip signal two; a fault in the clearing cycle wins
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         lat_oc_reg <= 1'b0;
      end else if (oc_fault && input_control_switches[`PSR_IC_LATCH_OC]) begin
         lat_oc_reg <= 1'b1;
      end else if (latch_clr) begin
         lat_oc_reg <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         lat_ef_reg <= 1'b0;
      end else if (ef_fault && input_control_switches[`PSR_IC_LATCH_EF]) begin
         lat_ef_reg <= 1'b1;
      end else if (latch_clr) begin
         lat_ef_reg <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         remote_rst_d_reg <= 1'b0;
         rec_clear        <= 1'b0;
      end else begin
         remote_rst_d_reg <= remote_rst;
         rec_clear        <= remote_rst && !remote_rst_d_reg;
      end
   end

   // ==========================================================
   // Relay outputs
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         trip_open <= 1'b0;
         signal1   <= 1'b0;
         signal2   <= 1'b0;
         signal3   <= 1'b0;
         signal4   <= 1'b0;
      end else begin
         trip_open <= oc_fault || ef_fault || lat_oc_reg || lat_ef_reg;
         signal1   <= |(stage_start & s1_start_mask);
         signal2   <= |(stage_start & s2_start_mask) || |(trip_eff & s2_trip_mask);
         signal3   <= |(trip_eff & s3_trip_mask);
         signal4   <= |(trip_eff & s4_trip_mask);
      end
   end

   // ==========================================================
   // Stage control outputs
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         bank2_sel   <= 1'b0;
         ph_low_char <= 3'h0;
         ef_low_char <= 3'h0;
         cbfp_en     <= 1'b0;
         hs_double   <= 1'b0;
      end else begin
         bank2_sel   <= ctrl_in && input_control_switches[`PSR_IC_BANK2];
         ph_low_char <= function_select_switches[2:0];
         ef_low_char <= function_select_switches[7:5];
         cbfp_en     <= function_select_switches[`PSR_FS_CBFP];
         hs_double   <= energizing && function_select_switches[`PSR_FS_HS_DOUBLE];
      end
   end

   // ==========================================================
   // Interrupts
   logic trip_open_d_reg;
   logic lat_any_d_reg;
   logic blk_any_d_reg;
   logic blk_any;

   assign blk_any = |(stage_trip & ~trip_eff);

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         trip_open_d_reg <= 1'b0;
         lat_any_d_reg   <= 1'b0;
         blk_any_d_reg   <= 1'b0;
      end else begin
         trip_open_d_reg <= trip_open;
         lat_any_d_reg   <= lat_oc_reg || lat_ef_reg;
         blk_any_d_reg   <= blk_any;
      end
   end

   always_comb begin
      ev_set                      = 4'h0;
      ev_set[`PSR_EV_OPEN]        = trip_open && !trip_open_d_reg;
      ev_set[`PSR_EV_BLOCK]       = blk_any && !blk_any_d_reg;
      ev_set[`PSR_EV_LATCH]       = (lat_oc_reg || lat_ef_reg) && !lat_any_d_reg;
      ev_set[`PSR_EV_REMOTE_RST]  = rec_clear;
      irq_status_next = irq_status_reg;
      if (wr_st) begin
         irq_status_next = irq_status_reg & ~reg_wr_data[3:0];
      end
      irq_status_next = irq_status_next | ev_set;
   end

   // Next mask so that irq follows status and mask of the same cycle
   assign irq_mask_next = wr_mk ? reg_wr_data[3:0] : irq_mask_reg;

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         irq_status_reg <= 4'h0;
         irq_mask_reg   <= `PSR_RST_IRQ_MASK;
         irq            <= 1'b0;
      end else begin
         irq_status_reg <= irq_status_next;
         if (wr_mk) begin
            irq_mask_reg <= reg_wr_data[3:0];
         end
         irq <= |(irq_status_next & irq_mask_next);
      end
   end

   // ==========================================================
   // Register read
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         reg_rd_data <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            `PSR_OFF_INPUT_CTRL:  reg_rd_data <= input_control_switches;
            `PSR_OFF_ROUTE_OPEN1: reg_rd_data <= routing_group_open_signal1;
            `PSR_OFF_ROUTE_SIG34: reg_rd_data <= routing_group_signal3_signal4;
            `PSR_OFF_ROUTE_SIG2:  reg_rd_data <= routing_group_signal2;
            `PSR_OFF_FUNC_SEL:    reg_rd_data <= function_select_switches;
            `PSR_OFF_IRQ_STATUS:  reg_rd_data <= {4'h0, irq_status_reg};
            `PSR_OFF_IRQ_MASK:    reg_rd_data <= {4'h0, irq_mask_reg};
            `PSR_OFF_LIVE_STATE:  reg_rd_data <= {ctrl_in, bank2_sel, lat_ef_reg, lat_oc_reg,
                                                  signal4, signal3, signal2, trip_open};
            default:              reg_rd_data <= 8'h00;
         endcase
      end else begin
         reg_rd_data <= 8'h00;
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence s_oc_fault;
      oc_fault && input_control_switches[`PSR_IC_LATCH_OC];
   endsequence

   sequence s_oc_quiet;
      !oc_fault && !ef_fault && !latch_clr;
   endsequence

   a_block_stage: assert property (
      (stage_trip == 4'h1 && ctrl_in && input_control_switches[0]
       && !lat_oc_reg && !lat_ef_reg) |=> !trip_open)
      else $error("blocked phase low-set trip reached open output");

   a_open_route: assert property (
      (stage_trip[0] && open_trip_mask[0] && !(ctrl_in && blk_mask[0])) |=> trip_open)
      else $error("routed trip did not drive open output");

   a_signal1_route: assert property (
      (stage_start[1] && s1_start_mask[1]) |=> signal1)
      else $error("routed start did not drive signal 1");

   a_signal34_route: assert property (
      (trip_eff == 4'h8 && s3_trip_mask[3] == 1'b0) |=> !signal3 && signal4 == $past(s4_trip_mask[3]))
      else $error("earth high-set trip routed wrongly to signal 3 or 4");

   a_signal2_idle: assert property (
      (stage_start == 4'h0 && trip_eff == 4'h0) |=> !signal2)
      else $error("signal 2 set with no routed source");

   a_bank_switch: assert property (
      (ctrl_in && input_control_switches[`PSR_IC_BANK2]) |=> bank2_sel ##1 (bank2_sel || !$past(ctrl_in)))
      else $error("second setting bank not selected");

   a_oc_latch: assert property (
      s_oc_fault ##1 s_oc_quiet |=> lat_oc_reg && trip_open)
      else $error("trip signal two did not stay latched");

   a_ef_latch: assert property (
      (ef_fault && input_control_switches[`PSR_IC_LATCH_EF]) |=> lat_ef_reg)
      else $error("earth fault latch not taken");

   a_remote_reset: assert property (
      (remote_rst && !remote_rst_d_reg) |=> rec_clear ##1 !rec_clear)
      else $error("recorded value clear pulse wrong");

   a_hs_double: assert property (
      (energizing && function_select_switches[`PSR_FS_HS_DOUBLE]) |=> hs_double)
      else $error("high-set start doubling not applied");

   a_irq_level: assert property (
      (|(irq_status_reg & irq_mask_reg)) |-> irq)
      else $error("interrupt low with unmasked status set");

   a_status_sticky: assert property (
      !wr_st |=> (irq_status_reg & $past(irq_status_reg)) == $past(irq_status_reg))
      else $error("status bit lost without a clearing write");

   a_reset_route: assert property (
      $fell(rst) |-> routing_group_open_signal1 == `PSR_RST_ROUTE_OPEN1
                     && routing_group_signal3_signal4 == `PSR_RST_ROUTE_SIG34)
      else $error("routing groups not at reset defaults");

endmodule : psr_matrix

/* sim/psr_stage_model.sv */
/*
 Model of the protection stage comparators and of the binary control input.
 Assumes the bench drives fault, slow and ctrl_req on rising edges of sys_clk.
*/
`timescale 1ns/1ps
module psr_stage_model (
   // Clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst,
   // Bench commands
   input  wire logic [3:0] fault,
   input  wire logic       slow,
   input  wire logic       ctrl_req,
   // Toward the matrix
   output logic      [3:0] stage_start,
   output logic      [3:0] stage_trip,
   output logic            ctrl_in
);
   logic [3:0] fault_reg;
   int         hold_cnt;

   // ==========================================================
   // Comparators: start at once, trip after a short or long operate delay
   always_ff @(posedge sys_clk) begin
      fault_reg   <= fault;
      stage_start <= rst ? 4'h0 : fault;
      if (rst || fault != fault_reg) begin
         hold_cnt   <= 0;
         stage_trip <= 4'h0;
      end else begin
         hold_cnt   <= hold_cnt + 1;
         stage_trip <= (hold_cnt >= (slow ? 6 : 1)) ? fault : 4'h0;
      end
   end

   // Energized input shown as an active high level
   always_ff @(posedge sys_clk) begin
      ctrl_in <= rst ? 1'b0 : ctrl_req;
   end
endmodule : psr_stage_model

/* sim/testbench.sv */
/*
 Self-checking bench of the protection signal routing matrix.
 Assumes the design files and the stage model are compiled first.
*/
`timescale 1ns/1ps
`include "psr_regs.svh"
module testbench;
   // ==========================================================
   // Signals
   logic       sys_clk     = 1'b0;
   logic       rst         = 1'b1;
   logic [7:0] reg_addr    = 8'h00;
   logic [7:0] reg_wr_data = 8'h00;
   logic       reg_wr      = 1'b0;
   logic       reg_rd      = 1'b0;
   logic [3:0] fault       = 4'h0;
   logic       slow        = 1'b0;
   logic       ctrl_req    = 1'b0;
   logic       energizing  = 1'b0;
   logic [7:0] reg_rd_data;
   logic [3:0] stage_start;
   logic [3:0] stage_trip;
   logic       ctrl_in;
   logic       trip_open, signal1, signal2, signal3, signal4;
   logic       bank2_sel, cbfp_en, hs_double, rec_clear, irq;
   logic [2:0] ph_low_char, ef_low_char;
   int         err_total   = 0;
   int         cmp_count   = 0;
   int         cyc         = 0;
   int         rec_cnt     = 0;
   int         rec_before;
   localparam logic [7:0] FVALS [6] = '{8'h07, 8'he0, 8'h08, 8'h10, 8'hff, 8'h00};

   always #4 sys_clk = ~sys_clk;

   psr_stage_model i_model (.sys_clk(sys_clk), .rst(rst), .fault(fault), .slow(slow), .ctrl_req(ctrl_req),
      .stage_start(stage_start), .stage_trip(stage_trip), .ctrl_in(ctrl_in));

   psr_matrix i_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data), .stage_start(stage_start),
      .stage_trip(stage_trip), .ctrl_in(ctrl_in), .energizing(energizing), .trip_open(trip_open),
      .signal1(signal1), .signal2(signal2), .signal3(signal3), .signal4(signal4), .bank2_sel(bank2_sel),
      .ph_low_char(ph_low_char), .ef_low_char(ef_low_char), .cbfp_en(cbfp_en), .hs_double(hs_double),
      .rec_clear(rec_clear), .irq(irq));

   // ==========================================================
   // Tasks
   task automatic finish_test;
      $display("Comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : finish_test

   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (rec_clear === 1'b1) begin
         rec_cnt <= rec_cnt + 1;
      end
      if (cyc == 10000) begin
         err_total++;
         finish_test();
      end
   end

   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask : tick

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr      <= 1'b1;
      reg_addr    <= a;
      reg_wr_data <= d;
      @(posedge sys_clk);
      reg_wr      <= 1'b0;
   endtask : wr

   // Read data is sampled at the edge that closes the cycle after the strobe
   task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
      @(posedge sys_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd   <= 1'b0;
      @(posedge sys_clk);
      chk(name, exp, reg_rd_data);
   endtask : rd

   task automatic stim(input logic [3:0] f, input logic c);
      @(posedge sys_clk);
      fault    <= f;
      ctrl_req <= c;
   endtask : stim

   task automatic pulse(input logic [3:0] f);
      stim(f, 1'b0);
      tick(14);
      stim(4'h0, 1'b0);
      tick(14);
   endtask : pulse

   function automatic logic [7:0] exp_out(input logic [7:0] o1, s34, s2, ctl, input logic c,
                                          input logic [3:0] f);
      logic [3:0] t;
      logic [7:0] r;
      t = f & ~(ctl[3:0] & {4{c}});
      r = 8'h00;
      for (int i = 0; i < 4; i++) begin
         r[0] |= t[i] & o1[2*i+1];
         r[1] |= f[i] & o1[2*i];
         r[2] |= (f[i] & s2[2*i]) | (t[i] & s2[2*i+1]);
         r[3] |= t[i] & s34[2*i];
         r[4] |= t[i] & s34[2*i+1];
      end
      return r;
   endfunction : exp_out

   task automatic route(input logic [7:0] o1, s34, s2, ctl, input logic c, input logic [3:0] f,
                        input string name);
      wr(`PSR_OFF_ROUTE_OPEN1, o1);
      wr(`PSR_OFF_ROUTE_SIG34, s34);
      wr(`PSR_OFF_ROUTE_SIG2, s2);
      wr(`PSR_OFF_INPUT_CTRL, ctl);
      stim(f, c);
      tick(14);
      chk(name, exp_out(o1, s34, s2, ctl, c, f), {3'h0, signal4, signal3, signal2, signal1, trip_open});
      stim(4'h0, 1'b0);
      tick(14);
   endtask : route

   // ==========================================================
   // Main sequence
   initial begin
      tick(4);
      rst <= 1'b0;
      chk("outs_after_reset", 8'h00, {3'h0, signal4, signal3, signal2, signal1, trip_open});
      rd(`PSR_OFF_INPUT_CTRL, 8'h00, "input_control_switches");
      rd(`PSR_OFF_ROUTE_OPEN1, 8'hab, "routing_group_open_signal1");
      rd(`PSR_OFF_ROUTE_SIG34, 8'ha5, "routing_group_signal3_signal4");
      rd(`PSR_OFF_ROUTE_SIG2, 8'h00, "routing_group_signal2");
      rd(`PSR_OFF_FUNC_SEL, 8'h00, "function_select_switches");
      rd(`PSR_OFF_IRQ_MASK, 8'h00, "irq_mask");
      rd(8'h24, 8'h00, "unmapped");
      for (int i = 0; i < 4; i++) route(8'hab, 8'ha5, 8'h00, 8'h00, 1'b0, 4'h1 << i, "default_route");
      for (int b = 0; b < 8; b++) begin
         slow <= b[0];
         route(8'h01 << b, 8'h01 << b, 8'h01 << b, 8'h00, 1'b0, 4'h1 << (b / 2), "single_bit");
         route(8'h01 << b, 8'h01 << b, 8'h01 << b, 8'h00, 1'b0, 4'h1 << ((b / 2 + 1) % 4), "other_stage");
      end
      route(8'h55, 8'haa, 8'h55, 8'h00, 1'b0, 4'h6, "or_of_starts");
      for (int i = 0; i < 4; i++) begin
         route(8'hab, 8'ha5, 8'haa, 8'h01 << i, 1'b1, 4'h1 << i, "blocked");
         route(8'hab, 8'ha5, 8'haa, 8'h01 << i, 1'b0, 4'h1 << i, "not_blocked");
      end
      route(8'hab, 8'ha5, 8'haa, 8'h0e, 1'b1, 4'hf, "block_three");
      wr(`PSR_OFF_INPUT_CTRL, 8'h10);
      stim(4'h0, 1'b1);
      tick(4);
      chk("bank2_on", 8'h01, {7'h0, bank2_sel});
      stim(4'h0, 1'b0);
      tick(4);
      chk("bank2_idle", 8'h00, {7'h0, bank2_sel});
      wr(`PSR_OFF_INPUT_CTRL, 8'h00);
      stim(4'h0, 1'b1);
      tick(4);
      chk("bank2_off", 8'h00, {7'h0, bank2_sel});
      wr(`PSR_OFF_INPUT_CTRL, 8'h20);
      pulse(4'h1);
      chk("oc_latch", 8'h01, {7'h0, trip_open});
      rd(`PSR_OFF_LIVE_STATE, 8'h11, "live_state");
      wr(`PSR_OFF_LIVE_STATE, 8'hff);
      rd(`PSR_OFF_LIVE_STATE, 8'h11, "live_read_only");
      wr(`PSR_OFF_COMMAND, 8'h01);
      tick(3);
      chk("latch_cleared", 8'h00, {7'h0, trip_open});
      pulse(4'h4);
      chk("oc_latch_earth", 8'h00, {7'h0, trip_open});
      wr(`PSR_OFF_INPUT_CTRL, 8'h40);
      pulse(4'h4);
      chk("ef_latch", 8'h01, {7'h0, trip_open});
      wr(`PSR_OFF_COMMAND, 8'h01);
      pulse(4'h1);
      chk("ef_latch_phase", 8'h00, {7'h0, trip_open});
      pulse(4'h8);
      stim(4'h0, 1'b1);
      tick(4);
      chk("remote_disabled", 8'h01, {7'h0, trip_open});
      stim(4'h0, 1'b0);
      tick(2);
      wr(`PSR_OFF_INPUT_CTRL, 8'hc0);
      rec_before = rec_cnt;
      stim(4'h0, 1'b1);
      tick(4);
      chk("remote_reset", 8'h00, {7'h0, trip_open});
      chk("rec_clear", 8'h01, 8'(rec_cnt - rec_before));
      stim(4'h0, 1'b0);
      wr(`PSR_OFF_INPUT_CTRL, 8'h00);
      rd(`PSR_OFF_IRQ_STATUS, 8'h0f, "irq_status_all");
      wr(`PSR_OFF_IRQ_STATUS, 8'h0f);
      pulse(4'h1);
      rd(`PSR_OFF_IRQ_STATUS, 8'h01, "irq_status_open");
      chk("irq_masked", 8'h00, {7'h0, irq});
      wr(`PSR_OFF_IRQ_MASK, 8'h01);
      tick(2);
      chk("irq_raised", 8'h01, {7'h0, irq});
      wr(`PSR_OFF_IRQ_MASK, 8'h02);
      tick(2);
      chk("irq_other_mask", 8'h00, {7'h0, irq});
      wr(`PSR_OFF_IRQ_STATUS, 8'h01);
      rd(`PSR_OFF_IRQ_STATUS, 8'h00, "irq_status_cleared");
      wr(`PSR_OFF_INPUT_CTRL, 8'h01);
      stim(4'h1, 1'b1);
      tick(14);
      stim(4'h0, 1'b0);
      rd(`PSR_OFF_IRQ_STATUS, 8'h02, "irq_status_blocked");
      tick(2);
      chk("irq_blocked", 8'h01, {7'h0, irq});
      for (int k = 0; k < 6; k++) begin
         wr(`PSR_OFF_FUNC_SEL, FVALS[k]);
         energizing <= k[0];
         tick(3);
         chk("ph_low_char", {5'h0, FVALS[k][2:0]}, {5'h0, ph_low_char});
         chk("cbfp_en", {7'h0, FVALS[k][3]}, {7'h0, cbfp_en});
         chk("hs_double", {7'h0, FVALS[k][4] & k[0]}, {7'h0, hs_double});
         chk("ef_low_char", {5'h0, FVALS[k][7:5]}, {5'h0, ef_low_char});
         rd(`PSR_OFF_FUNC_SEL, FVALS[k], "function_select_switches");
      end
      finish_test();
   end
endmodule : testbench
